// ===== hdl/asr_host.sv
// host controller driving a 32k x 8 asynchronous static ram over its pins
// Functional notes
// (R1) memory holds 32k bytes, 15-bit address, one shared two-way byte bus
// (R2) memory has one low chip select and one low output gate
// (R3) memory is clockless static; host needs no refresh sequencing
// (R4) host keeps write strobe high for the whole of every read
// (R5) back-to-back reads keep select and gate low; data follows address
// (R6) address is valid no later than chip select falling
// (R7) write happens only while select and strobe are both low
// (R8) select or strobe stays high whenever any address line changes
// (R9) select falling with or after strobe keeps memory outputs floating
// (R10) host never drives data while the memory may still drive it
// (R11) with gate low, strobe must cover float delay plus data overlap
// (R12) with gate high, the plain minimum strobe width suffices
// (R13) select-controlled write may leave gate low without lengthening
// (R14) write recovery counts from the first of select or strobe rising
// (R15) select high deselects memory, data lines floating
// (R16) select low, strobe high, gate low: memory drives addressed byte
// (R17) memory keeps a written byte until rewritten
`timescale 1ns/1ns
module asr_host
  import asr_pkg::*;
#(
  parameter int CNT_W = 4
) (
  // clock, reset, enable
  input  wire logic              ref_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              ce_i,
  // command port
  input  wire logic              req_i,
  input  wire asr_cmd_s          cmd_i,
  output logic                   ack_o,
  output logic                   rd_valid_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   idle_o,
  // memory pins
  output asr_pins_s              pins_o,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe_o
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  // release is synchronised; assertion stays asynchronous
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      {rst_n_reg, rst_meta_reg} <= 2'h0;
    else
      {rst_n_reg, rst_meta_reg} <= {rst_meta_reg, 1'b1};
  end

  // ---------------------------------------------------------------
  // state and phase timer
  // ---------------------------------------------------------------
  asr_state_e       state_reg;
  asr_state_e       state_next;
  asr_cmd_s         cmd_reg;
  logic             tick_zero;
  logic             load;
  logic [CNT_W-1:0] load_val;
  logic             take;

  asr_ticker #(.CNT_W(CNT_W)) u_ticker (
    .clk_i      (ref_clk_i),
    .rst_n_i    (rst_n_reg),
    .ce_i       (ce_i),
    .load_i     (load),
    .load_val_i (load_val),
    .zero_o     (tick_zero)
  );

  // a read may be chained only from the last read cycle, so select and
  // gate stay low across it and only the address moves
  always_comb
  begin
    take = req_i && ((state_reg == ST_IDLE) ||
                     (state_reg == ST_READ && tick_zero && !cmd_i.wr)); // R5
  end

  // next state and phase length
  always_comb
  begin
    state_next = state_reg;
    load       = 1'b0;
    load_val   = '0;
    case (state_reg)
      ST_IDLE:
      begin
        if (take)
        begin
          load       = 1'b1;
          state_next = cmd_i.wr ? ST_SETUP : ST_READ;
          load_val   = cmd_i.wr ? CNT_W'(SETUP_CYC - 1)
                                : CNT_W'(READ_CYC - 1);
        end
      end
      ST_READ:
      begin
        if (tick_zero)
        begin
          // memory keeps driving a while after deselect, hence float
          load       = 1'b1;
          state_next = take ? ST_READ : ST_FLOAT; // R5 R10
          load_val   = take ? CNT_W'(READ_CYC - 1)
                            : CNT_W'(FLOAT_CYC - 1);
        end
      end
      ST_FLOAT, ST_HOLD:
      begin
        if (tick_zero)
          state_next = ST_IDLE;
      end
      ST_SETUP:
      begin
        if (tick_zero)
        begin
          state_next = ST_STROBE;
          load       = 1'b1;
          load_val   = CNT_W'(STROBE_CYC - 1); // R11 R12
        end
      end
      ST_STROBE:
      begin
        if (tick_zero)
        begin
          state_next = ST_HOLD;
          load       = 1'b1;
          load_val   = CNT_W'(RECOV_CYC - 1); // R14
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      state_reg <= ST_IDLE;
    else if (ce_i)
      state_reg <= state_next;
  end

  // command latch: write data is driven from here; the address goes to the pins straight from the raw port on take
  always_ff @(posedge ref_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      cmd_reg <= '{wr: 1'b0, addr: ADDR_RST, wdata: DATA_RST};
    else if (ce_i && take)
      cmd_reg <= cmd_i;
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  asr_pins_s pins_next;
  logic      dq_oe_next;

  // strobe-controlled write with the gate kept high, so the memory
  // outputs are already floating and no pulse stretch is needed
  always_comb
  begin
    pins_next      = PINS_RST;
    pins_next.addr = pins_o.addr;
    dq_oe_next     = 1'b0;
    case (state_next)
      ST_READ:
      begin
        pins_next.addr = take ? cmd_i.addr : cmd_reg.addr; // R6
        pins_next.cs_n = 1'b0;
        pins_next.oe_n = 1'b0;
        pins_next.we_n = 1'b1; // R4
      end
      ST_SETUP:
      begin
        pins_next.addr = take ? cmd_i.addr : cmd_reg.addr; // R6 R8
        pins_next.cs_n = 1'b0;
      end
      ST_STROBE:
      begin
        pins_next.cs_n = 1'b0;
        pins_next.we_n = 1'b0; // R7 R12 R13
        dq_oe_next     = 1'b1; // R10
      end
      ST_HOLD:
      begin
        pins_next.cs_n = 1'b0; // R14
        dq_oe_next     = 1'b1;
      end
      default:
      begin
        pins_next.cs_n = 1'b1; // R15
      end
    endcase
  end

  // pin flops; address only moves while strobe is high
  always_ff @(posedge ref_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      pins_o  <= PINS_RST;
      dq_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pins_o  <= pins_next;
      dq_oe_o <= dq_oe_next;
    end
  end

  // write data held one cycle past the strobe rise as hold margin
  always_ff @(posedge ref_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      dq_o <= DATA_RST;
    else if (ce_i && state_next == ST_STROBE)
      dq_o <= cmd_reg.wdata;
  end

  // ---------------------------------------------------------------
  // answers
  // ---------------------------------------------------------------
  // sample at the edge that closes the access window
  always_ff @(posedge ref_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      ack_o      <= 1'b0;
      rd_valid_o <= 1'b0;
      rdata_o    <= DATA_RST;
      idle_o     <= 1'b0;
    end
    else if (ce_i)
    begin
      ack_o      <= take;
      rd_valid_o <= (state_reg == ST_READ) && tick_zero;
      idle_o     <= (state_next == ST_IDLE);
      if (state_reg == ST_READ && tick_zero)
        rdata_o <= dq_i; // R16
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  read_we_high_a: assert property (@(posedge ref_clk_i) // R4
    disable iff (!rst_n_reg)
    (!pins_o.cs_n && !pins_o.oe_n) |-> pins_o.we_n)
    else $error("strobe low during read");
  addr_quiet_a: assert property (@(posedge ref_clk_i) // R8
    disable iff (!rst_n_reg)
    $changed(pins_o.addr) |-> (pins_o.we_n && $past(pins_o.we_n)))
    else $error("address moved while strobe low");
  select_addr_a: assert property (@(posedge ref_clk_i) // R6
    disable iff (!rst_n_reg)
    $fell(pins_o.cs_n) |-> (pins_o.addr == cmd_reg.addr))
    else $error("address not valid at select fall");
  no_contend_a: assert property (@(posedge ref_clk_i) // R10
    disable iff (!rst_n_reg)
    dq_oe_o |-> (pins_o.oe_n && !pins_o.cs_n))
    else $error("data driven while memory may drive");
  read_float_a: assert property (@(posedge ref_clk_i) // R10
    disable iff (!rst_n_reg)
    $rose(pins_o.oe_n) |-> !dq_oe_o [*3])
    else $error("data driven before memory floats");
  pulse_width_a: assert property (@(posedge ref_clk_i) // R12
    disable iff (!rst_n_reg || !ce_i)
    $fell(pins_o.we_n) |-> (!pins_o.we_n && pins_o.oe_n) [*4])
    else $error("write strobe too short");
  data_overlap_a: assert property (@(posedge ref_clk_i) // R11
    disable iff (!rst_n_reg || !ce_i)
    $rose(pins_o.we_n) |-> ($past(dq_oe_o, 3) && dq_oe_o))
    else $error("data overlap too short");
  recovery_a: assert property (@(posedge ref_clk_i) // R14
    disable iff (!rst_n_reg || !ce_i)
    $rose(pins_o.we_n) |-> !pins_o.cs_n ##1 pins_o.cs_n)
    else $error("write recovery not kept");
  b2b_read_a: assert property (@(posedge ref_clk_i) // R5
    disable iff (!rst_n_reg || !ce_i)
    rd_valid_o |-> ($past(!pins_o.oe_n, 6) && $past(!pins_o.cs_n, 6)))
    else $error("read sampled before access time");

endmodule : asr_host

// ===== hdl/asr_pkg.sv
// shared constants, pin carrier and state codes for the static ram host
package asr_pkg;

  // ---------------------------------------------------------------
  // geometry of the attached memory
  // ---------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;

  // ---------------------------------------------------------------
  // clock and pin timing, in ns as printed for the slowest grade kept
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS         = 10;
  localparam int READ_CYCLE_NS         = 55;
  localparam int ADDR_ACCESS_NS        = 55;
  localparam int WRITE_PULSE_NS        = 40;
  localparam int DATA_SETUP_OVERLAP_NS = 25;
  localparam int STROBE_TO_FLOAT_NS    = 25;
  localparam int DESELECT_FLOAT_NS     = 25;
  localparam int WRITE_RECOVERY_NS     = 0;

  // ---------------------------------------------------------------
  // cycle counts: least times round up, none below one cycle
  // ---------------------------------------------------------------
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  localparam int READ_CYC   = max2(ns_to_cyc(READ_CYCLE_NS),
                                   ns_to_cyc(ADDR_ACCESS_NS));
  localparam int STROBE_CYC = max2(ns_to_cyc(WRITE_PULSE_NS),
                                   ns_to_cyc(DATA_SETUP_OVERLAP_NS));
  localparam int FLOAT_CYC  = max2(ns_to_cyc(DESELECT_FLOAT_NS),
                                   ns_to_cyc(STROBE_TO_FLOAT_NS));
  localparam int RECOV_CYC  = ns_to_cyc(WRITE_RECOVERY_NS);
  localparam int SETUP_CYC  = 1;

  // ---------------------------------------------------------------
  // pin idle values
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // ---------------------------------------------------------------
  // carriers and states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              cs_n;
    logic              we_n;
    logic              oe_n;
  } asr_pins_s;

  localparam asr_pins_s PINS_RST = '{addr: ADDR_RST, cs_n: 1'b1,
                                     we_n: 1'b1, oe_n: 1'b1};

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asr_cmd_s;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_READ   = 6'h02,
    ST_FLOAT  = 6'h04,
    ST_SETUP  = 6'h08,
    ST_STROBE = 6'h10,
    ST_HOLD   = 6'h20
  } asr_state_e;

endpackage : asr_pkg

// ===== hdl/asr_ticker.sv
// down counter that times each phase of a pin cycle
`timescale 1ns/1ns
module asr_ticker #(
  parameter int CNT_W = 4
) (
  // clock, reset, enable
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  // load and status
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] load_val_i,
  output logic                  zero_o
);

  logic [CNT_W-1:0] cnt_reg;

  // load wins over counting; holds at zero until the next load
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_reg <= '0;
    else if (ce_i)
    begin
      if (load_i)
        cnt_reg <= load_val_i;
      else if (cnt_reg != '0)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign zero_o = (cnt_reg == '0);

endmodule : asr_ticker

// ===== tb/asr_mem_model.sv
// behavioural model of the 32k x 8 static ram seen from its pins
`timescale 1ns/1ns
module asr_mem_model
  import asr_pkg::*;
#(
  parameter int ACC_NS = 55
) (
  // pins from the host
  input  wire asr_pins_s         pins_i,
  input  wire logic [DATA_W-1:0] host_dq_i,
  input  wire logic              host_oe_i,
  // shared bus and fault count
  output logic [DATA_W-1:0]      bus_o,
  output int                     clash_o
);
  // ---------------------------------------------------------------
  // storage, no clock and no refresh anywhere in here
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] mout = 8'h00;
  logic [DATA_W-1:0] wd;
  logic [ADDR_W-1:0] wa;
  logic              wr_on = 1'b0;
  logic              drive;
  time               chg = 0;
  time               last_on = 0;

  initial clash_o = 0;
  // output only when selected, gate low, strobe high; else float
  assign drive = !pins_i.cs_n && pins_i.we_n && !pins_i.oe_n;
  assign bus_o = host_oe_i ? host_dq_i : mout;
  always @(pins_i) chg = $time;
  // a floating or unsettled bus toggles, so stale data never passes
  always
  begin
    #1;
    // outputs linger after drive ends, so a host drive inside that
    // float time counts as a clash as well
    if (drive) last_on = $time;
    if (host_oe_i && $time - last_on <= DESELECT_FLOAT_NS) clash_o++;
    if (drive && $time - chg >= ACC_NS) mout = mem[pins_i.addr];
    else mout = ~mout;
  end
  // write lasts while select and strobe are both low, commits at end
  always @(pins_i, host_dq_i, host_oe_i)
  begin
    if (!pins_i.cs_n && !pins_i.we_n)
    begin
      wr_on = 1'b1;
      wa = pins_i.addr;
      wd = host_oe_i ? host_dq_i : 8'hxx;
    end
    else if (wr_on)
    begin
      mem[wa] = wd;
      wr_on = 1'b0;
    end
  end
endmodule : asr_mem_model

// ===== tb/asr_host_test.sv
// self-checking bench for the static ram host against a memory model
`timescale 1ns/1ns
module asr_host_test;
  import asr_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic              ref_clk_i, rstn_i, ce_i, req_i, ce_q;
  logic              ack_o, rd_valid_o, idle_o, dq_oe_o;
  asr_cmd_s          cmd_i;
  asr_pins_s         pins_o, prev;
  logic [DATA_W-1:0] rdata_o, dq_o, dq_i;
  logic [DATA_W-1:0] shadow [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] expq [$];
  logic [ADDR_W-1:0] wa [$];
  logic [ADDR_W-1:0] cur_a;
  int                errors, comparisons, clash, seed, wlow;

  asr_host #(.CNT_W(4)) i_asr_host (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .ce_i(ce_i), .req_i(req_i), .cmd_i(cmd_i), .ack_o(ack_o),
    .rd_valid_o(rd_valid_o), .rdata_o(rdata_o), .idle_o(idle_o),
    .pins_o(pins_o), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
  asr_mem_model i_asr_mem_model (.pins_i(pins_o), .host_dq_i(dq_o),
    .host_oe_i(dq_oe_o), .bus_o(dq_i), .clash_o(clash));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [ADDR_W-1:0] exp,
                       input logic [ADDR_W-1:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // least strobe low time; with the gate low it must also cover turn-off
  function automatic int min_strobe_ns(input logic gate_n);
    int longer;
    longer = STROBE_TO_FLOAT_NS + DATA_SETUP_OVERLAP_NS;
    if (gate_n || longer < WRITE_PULSE_NS) return WRITE_PULSE_NS;
    return longer;
  endfunction : min_strobe_ns

  // ack counts only if made by an enabled edge, not held by a freeze
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] d;
    int n;
    d = DATA_W'($random(seed));
    cur_a <= a;
    req_i <= 1'b1;
    cmd_i <= '{wr: wr, addr: a, wdata: d};
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (!(ack_o === 1'b1 && ce_q) && n < 100);
    check("ack", 1, ADDR_W'(ack_o));
    if (wr) shadow[a] = d;
    if (wr) wa.push_back(a);
    else expq.push_back(shadow[a]);
  endtask : issue

  task automatic complete_run();
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // clock, watchdog and pin monitor
  // ---------------------------------------------------------------
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    #100000;
    errors++;
    complete_run();
  end
  // enable drops one edge in eight to stretch every phase
  always @(posedge ref_clk_i)
  begin
    ce_i <= ($random(seed) % 8) != 0;
    ce_q <= ce_i;
    prev <= pins_o;
    wlow <= pins_o.we_n ? 0 : wlow + 1;
    if (rstn_i && rd_valid_o === 1'b1 && ce_q)
    begin
      check("read queued", 1, ADDR_W'(expq.size() > 0));
      if (expq.size() > 0)
        check("rdata", ADDR_W'(expq.pop_front()), ADDR_W'(rdata_o));
    end
    if (rstn_i && !pins_o.cs_n && !pins_o.oe_n)
      check("we_n in read", 1, ADDR_W'(pins_o.we_n));
    if (rstn_i && pins_o.addr !== prev.addr)
      check("select or strobe", 1, ADDR_W'((pins_o.cs_n | pins_o.we_n)
        & (prev.cs_n | prev.we_n)));
    if (rstn_i && prev.cs_n && !pins_o.cs_n)
      check("address at select", cur_a, pins_o.addr);
    if (rstn_i && pins_o.we_n && wlow > 0)
      check("strobe width", 1, ADDR_W'(wlow * CLK_PERIOD_NS >=
        min_strobe_ns(prev.oe_n)));
  end

  // ---------------------------------------------------------------
  // main sequence: corners, then random reads and writes
  // ---------------------------------------------------------------
  initial
  begin
    seed = 27;
    errors = 0;
    comparisons = 0;
    wlow = 0;
    rstn_i = 1'b0;
    ce_i = 1'b1;
    ce_q = 1'b1;
    req_i = 1'b0;
    cmd_i = '0;
    cur_a = '0;
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    issue(1'b1, 15'h0000);
    issue(1'b1, 15'h7fff);
    issue(1'b0, 15'h7fff);
    issue(1'b0, 15'h0000);
    issue(1'b1, 15'h0000);
    issue(1'b0, 15'h0000);
    repeat (60)
    begin
      if ($random(seed) & 1) issue(1'b1, ADDR_W'($random(seed)));
      else issue(1'b0, wa[$unsigned($random(seed)) % wa.size()]);
    end
    req_i <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    check("reads left", 0, ADDR_W'(expq.size()));
    check("bus clash", 0, ADDR_W'(clash));
    check("idle", 1, ADDR_W'(idle_o));
    complete_run();
  end
endmodule : asr_host_test
